// ===== boot_sel_pkg.sv
// Constants and types shared by the boot mode select loader
package boot_sel_pkg;

  // Boot modes decoded from the straps
  typedef enum logic [2:0] {
    MODE_NONE  = 3'h0,
    MODE_EPROM = 3'h1,
    MODE_HOST  = 3'h2,
    MODE_LINK  = 3'h3,
    MODE_SPI   = 3'h4
  } boot_mode_t;

  // Sequencer states, Gray coded along settle, load, drain, run
  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_LOAD   = 2'h1,
    ST_DRAIN  = 2'h3,
    ST_RUN    = 2'h2
  } boot_state_t;

  // Word and address widths
  localparam int unsigned INSTR_W = 48;
  localparam int unsigned ADDR_W  = 20;
  localparam int unsigned UNIT_W  = 16;

  // Boot program layout
  localparam logic [8:0]        BOOT_WORDS     = 9'h100;
  localparam logic [ADDR_W-1:0] BOOT_BASE_ADDR = 20'h40000;
  localparam logic [ADDR_W-1:0] IDLE_PC        = 20'h40004;
  localparam logic [ADDR_W-1:0] WAKE_VECTOR    = 20'h40050;

  // DMA channels and link buffer per mode
  localparam logic [3:0] DMA_CH_EXT  = 4'hA;
  localparam logic [3:0] DMA_CH_SPI  = 4'h8;
  localparam logic [3:0] DMA_CH_LINK = 4'h4;
  localparam logic [2:0] LINK_BUFFER = 3'h4;

  // Source unit widths and units per instruction
  localparam logic [3:0] UNITS_BYTE   = 4'h6;
  localparam logic [3:0] UNITS_HALF   = 4'h3;
  localparam logic [3:0] UNITS_NIBBLE = 4'hC;

  // Cycles the synchronised straps must stay steady before latching
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

endpackage : boot_sel_pkg

// ===== boot_mode_select_loader.sv
// Boot mode select and 256-instruction boot loader
`timescale 1ns/1ps
`default_nettype none

module boot_mode_select_loader #(
  parameter int unsigned WORDS = 256
) (
  // Clock, reset, enable
  input  wire logic                 I_REF_CLK,
  input  wire logic                 I_NRST,
  input  wire logic                 I_CE,
  // Strap pins
  input  wire logic                 I_EPROM_BOOT_STRAP,
  input  wire logic                 I_LINK_BOOT_STRAP,
  // Boot memory select pin
  input  wire logic                 I_BOOT_MEMORY_SELECT_N,
  output logic                      O_BOOT_MEMORY_SELECT_N,
  output logic                      O_BOOT_MEMORY_SELECT_N_OE,
  // System state
  input  wire logic                 I_BUS_OWNER,
  input  wire logic                 I_HOST_WIDE,
  // Source unit stream (byte, halfword, nibble, SPI receive register)
  input  wire logic                 I_SRC_VALID,
  input  wire logic [15:0]          I_SRC_DATA,
  output logic                      O_SRC_READY,
  // Internal memory write stream
  output logic                      O_WR_VALID,
  output logic [19:0]               O_WR_ADDR,
  output logic [47:0]               O_WR_DATA,
  input  wire logic                 I_WR_READY,
  // Status
  output logic [2:0]                O_MODE,
  output logic [3:0]                O_DMA_CHANNEL,
  output logic [2:0]                O_LINK_BUFFER,
  output logic                      O_IDLE,
  output logic [19:0]               O_PC,
  output logic                      O_BOOT_DONE,
  output logic                      O_EXT_FETCH
);

  // Three-stage pin syncs run through reset, so straps are in at release
  logic [2:0] eb_sync_q;
  logic [2:0] lb_sync_q;
  logic [2:0] bms_sync_q;
  logic       pins_steady;

  always_ff @(posedge I_REF_CLK) begin
    if (I_CE) begin
      eb_sync_q  <= {eb_sync_q[1:0], I_EPROM_BOOT_STRAP};
      lb_sync_q  <= {lb_sync_q[1:0], I_LINK_BOOT_STRAP};
      bms_sync_q <= {bms_sync_q[1:0], I_BOOT_MEMORY_SELECT_N};
    end
  end

  assign pins_steady = (eb_sync_q[1] == eb_sync_q[2])
                     && (lb_sync_q[1] == lb_sync_q[2])
                     && (bms_sync_q[1] == bms_sync_q[2]);

  // Strap decode; EPROM strap high wins, select pin ignored as it is ours
  function automatic boot_sel_pkg::boot_mode_t decode_mode(
    input logic eb,
    input logic lb,
    input logic sel_n
  );
    boot_sel_pkg::boot_mode_t m;
    m = boot_sel_pkg::MODE_NONE;
    if (eb) m = boot_sel_pkg::MODE_EPROM;
    else if (!lb && sel_n) m = boot_sel_pkg::MODE_HOST;
    else if (lb && sel_n) m = boot_sel_pkg::MODE_LINK;
    else if (lb && !sel_n) m = boot_sel_pkg::MODE_SPI;
    else m = boot_sel_pkg::MODE_NONE;
    return m;
  endfunction : decode_mode

  // Units of source data that make one 48-bit instruction
  function automatic logic [3:0] units_for(
    input boot_sel_pkg::boot_mode_t m,
    input logic                     wide
  );
    logic [3:0] n;
    n = boot_sel_pkg::UNITS_BYTE;
    case (m)
      boot_sel_pkg::MODE_EPROM: n = boot_sel_pkg::UNITS_BYTE;
      boot_sel_pkg::MODE_HOST:  n = wide ? boot_sel_pkg::UNITS_HALF
                                         : boot_sel_pkg::UNITS_BYTE;
      boot_sel_pkg::MODE_LINK:  n = boot_sel_pkg::UNITS_NIBBLE;
      boot_sel_pkg::MODE_SPI:   n = boot_sel_pkg::UNITS_HALF;
      default:                  n = boot_sel_pkg::UNITS_BYTE;
    endcase
    return n;
  endfunction : units_for

  // Latched configuration and sequencer
  boot_sel_pkg::boot_state_t state_q, state_d;
  boot_sel_pkg::boot_mode_t  mode_q;
  logic [1:0]                settle_q;
  logic [3:0]                units_q;
  logic [3:0]                unit_cnt_q;
  logic [8:0]                word_cnt_q;
  logic [47:0]               pack_q;
  logic [47:0]               pack_next;
  logic [19:0]               addr_q;
  logic                      src_ready_q;

  // Two-entry buffer: output stage plus one skid entry
  logic        out_valid_q;
  logic [47:0] out_data_q;
  logic [19:0] out_addr_q;
  logic        skid_valid_q;
  logic [47:0] skid_data_q;
  logic [19:0] skid_addr_q;

  boot_sel_pkg::boot_mode_t mode_now;
  logic unit_take;
  logic last_unit;
  logic push;
  logic pop;
  logic last_word;
  logic load_end;
  logic skid_valid_d;
  logic out_valid_d;
  logic settle_ok;

  assign mode_now  = decode_mode(eb_sync_q[2], lb_sync_q[2], bms_sync_q[2]);
  assign settle_ok = (settle_q == boot_sel_pkg::SETTLE_CYCLES);
  // The ready flop already reflects a free skid entry, so no word is lost
  assign unit_take = (state_q == boot_sel_pkg::ST_LOAD) && src_ready_q
                   && I_SRC_VALID;
  assign last_unit = unit_take && (unit_cnt_q == units_q - 4'h1);
  assign push      = last_unit;
  assign pop       = out_valid_q && I_WR_READY;
  assign last_word = push && (word_cnt_q == 9'(WORDS - 1));
  assign load_end  = last_word;

  // New unit enters at the top, so the first unit ends lowest
  always_comb begin
    pack_next = pack_q;
    case (units_q)
      boot_sel_pkg::UNITS_HALF:   pack_next = {I_SRC_DATA, pack_q[47:16]};
      boot_sel_pkg::UNITS_NIBBLE: pack_next = {I_SRC_DATA[3:0],
                                                pack_q[47:4]};
      default:                    pack_next = {I_SRC_DATA[7:0],
                                                pack_q[47:8]};
    endcase
  end

  // Buffer occupancy after this cycle
  assign out_valid_d  = (out_valid_q && !pop) || push || skid_valid_q;
  assign skid_valid_d = (skid_valid_q && !pop)
                      || (push && out_valid_q && !pop && !skid_valid_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      boot_sel_pkg::ST_SETTLE: begin
        if (settle_ok) begin
          state_d = (mode_now == boot_sel_pkg::MODE_NONE)
                  ? boot_sel_pkg::ST_RUN : boot_sel_pkg::ST_LOAD;
        end
      end
      boot_sel_pkg::ST_LOAD: begin
        if (load_end) begin
          state_d = boot_sel_pkg::ST_DRAIN;
        end
      end
      boot_sel_pkg::ST_DRAIN: begin
        // Execution starts only once every word reached memory
        if (!out_valid_d) begin
          state_d = boot_sel_pkg::ST_RUN;
        end
      end
      boot_sel_pkg::ST_RUN:    state_d = boot_sel_pkg::ST_RUN;
      default:                 state_d = boot_sel_pkg::ST_SETTLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      state_q  <= boot_sel_pkg::ST_SETTLE;
      settle_q <= 2'h0;
    end else if (I_CE) begin
      state_q <= state_d;
      if (state_q == boot_sel_pkg::ST_SETTLE) begin
        settle_q <= !pins_steady ? 2'h0 : settle_ok ? settle_q
                  : settle_q + 2'h1;
      end
    end
  end

  // Mode taken once on leaving settle and held until next reset
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      mode_q  <= boot_sel_pkg::MODE_NONE;
      units_q <= boot_sel_pkg::UNITS_BYTE;
    end else if (I_CE && state_q == boot_sel_pkg::ST_SETTLE
                 && settle_ok) begin
      mode_q  <= mode_now;
      units_q <= units_for(mode_now, I_HOST_WIDE);
    end
  end

  // Packer and counters of the boot transfer
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      unit_cnt_q  <= 4'h0;
      word_cnt_q  <= 9'h000;
      pack_q      <= 48'h0;
      addr_q      <= boot_sel_pkg::BOOT_BASE_ADDR;
      src_ready_q <= 1'b0;
    end else if (I_CE) begin
      src_ready_q <= (state_d == boot_sel_pkg::ST_LOAD) && !skid_valid_d;
      if (unit_take) begin
        pack_q     <= pack_next;
        unit_cnt_q <= last_unit ? 4'h0 : unit_cnt_q + 4'h1;
      end
      if (push) begin
        word_cnt_q <= word_cnt_q + 9'h001;
        addr_q     <= addr_q + 20'h00001;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      out_valid_q  <= 1'b0;
      out_data_q   <= 48'h0;
      out_addr_q   <= 20'h0;
      skid_valid_q <= 1'b0;
      skid_data_q  <= 48'h0;
      skid_addr_q  <= 20'h0;
    end else if (I_CE) begin
      out_valid_q  <= out_valid_d;
      skid_valid_q <= skid_valid_d;
      if (!out_valid_q || pop) begin
        out_data_q <= skid_valid_q ? skid_data_q : pack_next;
        out_addr_q <= skid_valid_q ? skid_addr_q : addr_q;
      end
      if (push && out_valid_q && !pop && !skid_valid_q) begin
        skid_data_q <= pack_next;
        skid_addr_q <= addr_q;
      end
    end
  end

  // Status and pin outputs, all registered
  logic booting_d;
  logic eprom_d;
  assign booting_d = (state_d == boot_sel_pkg::ST_LOAD)
                   || (state_d == boot_sel_pkg::ST_DRAIN);
  assign eprom_d   = (mode_q == boot_sel_pkg::MODE_EPROM)
                   || (state_q == boot_sel_pkg::ST_SETTLE
                       && mode_now == boot_sel_pkg::MODE_EPROM);

  logic [3:0] chan_d;
  boot_sel_pkg::boot_mode_t mode_sel;
  assign mode_sel = (state_q == boot_sel_pkg::ST_SETTLE) ? mode_now : mode_q;
  assign chan_d = (mode_sel == boot_sel_pkg::MODE_SPI)
                ? boot_sel_pkg::DMA_CH_SPI
                : (mode_sel == boot_sel_pkg::MODE_LINK)
                ? boot_sel_pkg::DMA_CH_LINK
                : boot_sel_pkg::DMA_CH_EXT;

  logic [2:0]  mode_out_q;
  logic [3:0]  chan_q;
  logic [2:0]  link_buf_q;
  logic        idle_q;
  logic [19:0] pc_q;
  logic        done_q;
  logic        ext_fetch_q;
  logic        sel_n_q;
  logic        sel_oe_q;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      mode_out_q  <= 3'h0;
      chan_q      <= 4'h0;
      link_buf_q  <= 3'h0;
      idle_q      <= 1'b1;
      pc_q        <= boot_sel_pkg::IDLE_PC;
      done_q      <= 1'b0;
      ext_fetch_q <= 1'b0;
      sel_n_q     <= 1'b1;
      sel_oe_q    <= 1'b0;
    end else if (I_CE) begin
      mode_out_q <= mode_sel;
      chan_q     <= booting_d ? chan_d : 4'h0;
      link_buf_q <= (booting_d && mode_sel == boot_sel_pkg::MODE_LINK)
                  ? boot_sel_pkg::LINK_BUFFER : 3'h0;
      // Core waits as after an idle instruction until the drain ends and the sequencer reaches run
      idle_q     <= (state_d != boot_sel_pkg::ST_RUN);
      done_q     <= (state_d == boot_sel_pkg::ST_RUN) && booting_d == 1'b0
                  && (mode_sel != boot_sel_pkg::MODE_NONE);
      ext_fetch_q <= (state_d == boot_sel_pkg::ST_RUN)
                   && (mode_sel == boot_sel_pkg::MODE_NONE);
      if (state_d == boot_sel_pkg::ST_RUN
          && mode_sel != boot_sel_pkg::MODE_NONE) begin
        pc_q <= boot_sel_pkg::WAKE_VECTOR;
      end
      // Chip select low through load and drain in EPROM boot; released at run
      sel_n_q  <= !(booting_d && eprom_d);
      // Driven only in EPROM boot by the bus owner; else the pin floats
      sel_oe_q <= booting_d && eprom_d && I_BUS_OWNER;
    end
  end

  assign O_BOOT_MEMORY_SELECT_N    = sel_n_q;
  assign O_BOOT_MEMORY_SELECT_N_OE = sel_oe_q;
  assign O_SRC_READY   = src_ready_q;
  assign O_WR_VALID    = out_valid_q;
  assign O_WR_ADDR     = out_addr_q;
  assign O_WR_DATA     = out_data_q;
  assign O_MODE        = mode_out_q;
  assign O_DMA_CHANNEL = chan_q;
  assign O_LINK_BUFFER = link_buf_q;
  assign O_IDLE        = idle_q;
  assign O_PC          = pc_q;
  assign O_BOOT_DONE   = done_q;
  assign O_EXT_FETCH   = ext_fetch_q;

endmodule : boot_mode_select_loader

`default_nettype wire

// ===== boot_mode_select_loader_sva.sv
// Port checker for the boot mode select loader
`timescale 1ns/1ps
`default_nettype none
module boot_mode_select_loader_sva #(
  parameter int unsigned WORDS = 256
) (
  // Clock, reset and far-side inputs
  input wire logic        I_REF_CLK,
  input wire logic        I_NRST,
  input wire logic        I_CE,
  input wire logic        I_BUS_OWNER,
  input wire logic        I_WR_READY,
  // Outputs under watch
  input wire logic        O_BOOT_MEMORY_SELECT_N,
  input wire logic        O_BOOT_MEMORY_SELECT_N_OE,
  input wire logic        O_SRC_READY,
  input wire logic        O_WR_VALID,
  input wire logic [19:0] O_WR_ADDR,
  input wire logic [47:0] O_WR_DATA,
  input wire logic [2:0]  O_MODE,
  input wire logic [3:0]  O_DMA_CHANNEL,
  input wire logic [2:0]  O_LINK_BUFFER,
  input wire logic        O_IDLE,
  input wire logic [19:0] O_PC,
  input wire logic        O_BOOT_DONE,
  input wire logic        O_EXT_FETCH
);
  logic [9:0] words_q;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  // Words accepted by memory so far, to pin each address to its slot
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) words_q <= 10'h000;
    else if (I_CE && O_WR_VALID && I_WR_READY) words_q <= words_q + 10'h001;
  end
  reset_state_a: assert property (disable iff (1'b0)
    !I_NRST && I_CE |=> O_IDLE && O_PC == boot_sel_pkg::IDLE_PC
      && !O_WR_VALID && !O_SRC_READY && !O_BOOT_MEMORY_SELECT_N_OE
      && O_MODE == 3'h0) else $error("reset state wrong");
  write_hold_a: assert property (
    O_WR_VALID && !I_WR_READY |=> O_WR_VALID && $stable(O_WR_ADDR)
      && $stable(O_WR_DATA)) else $error("write word not held");
  addr_order_a: assert property (
    O_WR_VALID |-> O_WR_ADDR == boot_sel_pkg::BOOT_BASE_ADDR + 20'(words_q))
    else $error("write address out of order");
  spi_channel_a: assert property (
    O_SRC_READY && O_MODE == 3'h4
      |-> O_DMA_CHANNEL == boot_sel_pkg::DMA_CH_SPI)
    else $error("spi channel wrong");
  link_buffer_a: assert property (
    O_SRC_READY && O_MODE == 3'h3
      |-> O_LINK_BUFFER == boot_sel_pkg::LINK_BUFFER
      && O_DMA_CHANNEL == boot_sel_pkg::DMA_CH_LINK)
    else $error("link buffer wrong");
  eprom_select_a: assert property (
    O_SRC_READY && O_MODE == 3'h1 |-> !O_BOOT_MEMORY_SELECT_N)
    else $error("eprom select not asserted");
  owner_drive_a: assert property (
    O_BOOT_MEMORY_SELECT_N_OE |-> $past(I_BUS_OWNER) && O_MODE == 3'h1)
    else $error("select driven without ownership");
  owner_follow_a: assert property (
    O_MODE == 3'h1 && O_SRC_READY && $past(O_SRC_READY)
      |-> O_BOOT_MEMORY_SELECT_N_OE == $past(I_BUS_OWNER))
    else $error("select enable not following owner");
  done_state_a: assert property (
    O_BOOT_DONE |-> !O_IDLE && !O_SRC_READY && words_q == 10'(WORDS)
      && O_PC == boot_sel_pkg::WAKE_VECTOR) else $error("done state wrong");
  idle_pc_a: assert property (
    O_IDLE |-> O_PC == boot_sel_pkg::IDLE_PC) else $error("idle pc wrong");
  mode_fixed_a: assert property (
    O_MODE != 3'h0 |=> $stable(O_MODE)) else $error("mode changed");
  ext_fetch_a: assert property (
    O_EXT_FETCH |-> O_MODE == 3'h0 && !O_BOOT_DONE && !O_WR_VALID)
    else $error("external fetch in load mode");
  cover property (O_MODE == 3'h1 && O_WR_VALID && I_WR_READY);
  cover property (O_MODE == 3'h3 && O_BOOT_DONE);
  cover property (O_EXT_FETCH);
endmodule : boot_mode_select_loader_sva
bind boot_mode_select_loader boot_mode_select_loader_sva #(.WORDS(WORDS)) u_sva (
  .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_CE(I_CE),
  .I_BUS_OWNER(I_BUS_OWNER), .I_WR_READY(I_WR_READY),
  .O_BOOT_MEMORY_SELECT_N(O_BOOT_MEMORY_SELECT_N),
  .O_BOOT_MEMORY_SELECT_N_OE(O_BOOT_MEMORY_SELECT_N_OE),
  .O_SRC_READY(O_SRC_READY), .O_WR_VALID(O_WR_VALID), .O_WR_ADDR(O_WR_ADDR),
  .O_WR_DATA(O_WR_DATA), .O_MODE(O_MODE), .O_DMA_CHANNEL(O_DMA_CHANNEL),
  .O_LINK_BUFFER(O_LINK_BUFFER), .O_IDLE(O_IDLE), .O_PC(O_PC),
  .O_BOOT_DONE(O_BOOT_DONE), .O_EXT_FETCH(O_EXT_FETCH));
`default_nettype wire

// ===== boot_source_model.sv
// Boot source model: unit stream and select pin level of the far side
`timescale 1ns/1ps
`default_nettype none
module boot_source_model (
  // Control
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [4:0]  unit_bits,
  input  wire logic        hold_low,
  // Unit stream
  input  wire logic        ready,
  output logic             valid,
  output logic [15:0]      data,
  // Select pin level while the device does not drive it
  output logic             sel_level
);
  logic [15:0] sent[$];
  logic        tk;
  assign sel_level = !hold_low;
  initial begin
    valid = 1'b0;
    data = 16'h0000;
  end
  // Random gaps give both prompt and slow offers; an idle data line
  // is inverted on each idle cycle, so it alternates between the last unit and its inverse
  always @(posedge clk) begin
    tk = valid && ready;
    if (tk) sent.push_back(data);
    #1;
    if (!go) begin
      valid = 1'b0;
      data = ~data;
    end else if (tk || !valid) begin
      if ($urandom_range(3) != 0) begin
        valid = 1'b1;
        data = 16'($urandom) & ((16'h0001 << unit_bits) - 16'h0001);
      end else begin
        valid = 1'b0;
        data = ~data;
      end
    end
  end
endmodule : boot_source_model
`default_nettype wire

// ===== tb_boot_mode_select_loader.sv
// Self-checking bench for the boot mode select loader
`timescale 1ns/1ps
`default_nettype none
module tb_boot_mode_select_loader;
  localparam int unsigned W = 4;
  logic        clk, nrst, eb, lb, owner, wide, rdy, go, hold_low;
  logic        sel_o, sel_oe, sel_lvl, sel_wire, s_valid, s_ready;
  logic        wr_valid, idle, done, ext;
  logic [4:0]  ubits;
  logic [15:0] s_data;
  logic [19:0] wr_addr, pc;
  logic [47:0] wr_data;
  logic [2:0]  mode, lbuf;
  logic [3:0]  chan;
  int          err_count, check_count;
  assign sel_wire = sel_oe ? sel_o : sel_lvl;
  boot_mode_select_loader #(.WORDS(W)) dut (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_CE(1'b1),
    .I_EPROM_BOOT_STRAP(eb), .I_LINK_BOOT_STRAP(lb),
    .I_BOOT_MEMORY_SELECT_N(sel_wire), .O_BOOT_MEMORY_SELECT_N(sel_o),
    .O_BOOT_MEMORY_SELECT_N_OE(sel_oe), .I_BUS_OWNER(owner),
    .I_HOST_WIDE(wide), .I_SRC_VALID(s_valid), .I_SRC_DATA(s_data),
    .O_SRC_READY(s_ready), .O_WR_VALID(wr_valid), .O_WR_ADDR(wr_addr),
    .O_WR_DATA(wr_data), .I_WR_READY(rdy), .O_MODE(mode),
    .O_DMA_CHANNEL(chan), .O_LINK_BUFFER(lbuf), .O_IDLE(idle), .O_PC(pc),
    .O_BOOT_DONE(done), .O_EXT_FETCH(ext));
  boot_source_model src (
    .clk(clk), .go(go), .unit_bits(ubits), .hold_low(hold_low),
    .ready(s_ready), .valid(s_valid), .data(s_data), .sel_level(sel_lvl));
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic tick(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 40) begin
      err_count++;
      wrap_up();
    end
  endtask : tick
  // First unit of a word lands in the lowest bits
  function automatic logic [47:0] pack(input int base, nu, ub);
    logic [47:0] w;
    w = '0;
    for (int k = 0; k < nu; k++) w |= 48'(src.sent[base + k]) << (k * ub);
    return w;
  endfunction : pack
  task automatic run_mode(input logic e, l, s, h, input logic [2:0] em,
                          input int nu, ub, input logic [3:0] ech);
    int n;
    int got;
    logic [47:0] exp_w;
    @(posedge clk);
    #1;
    nrst = 1'b0; eb = e; lb = l; hold_low = !s; wide = h; go = 1'b0;
    ubits = 5'(ub);
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    src.sent.delete();
    n = 0;
    while (s_ready !== 1'b1 && ext !== 1'b1) tick(n);
    chk("mode", 48'(mode), 48'(em));
    chk("channel", 48'(chan), 48'(ech));
    chk("link buffer", 48'(lbuf), (em == 3'h3) ? 48'h4 : 48'h0);
    if (em == boot_sel_pkg::MODE_NONE) begin
      repeat (5) @(posedge clk);
      #1;
      chk("ext fetch", 48'(ext), 48'h1);
      chk("no load", 48'(s_ready), 48'h0);
      return;
    end
    go = 1'b1;
    got = 0;
    for (n = 0; n < 4000 && got < W; n++) begin
      @(posedge clk);
      #1;
      // A long stall first fills the buffer so the source is refused
      rdy = (n >= 59) ? 1'($urandom_range(1)) : 1'b0;
      owner = ($urandom_range(3) != 0);
      if (n == 59) chk("stall ready", 48'(s_ready), 48'h0);
      // Mid-cycle the word and ready stand settled for the coming edge
      @(negedge clk);
      if (wr_valid === 1'b1 && rdy === 1'b1) begin
        exp_w = 48'(boot_sel_pkg::BOOT_BASE_ADDR) + 48'(got);
        chk("addr", 48'(wr_addr), exp_w);
        exp_w = pack(got * nu, nu, ub);
        chk("data", wr_data, exp_w);
        got++;
      end
    end
    chk("words", 48'(got), 48'(W));
    @(posedge clk);
    #1;
    go = 1'b0;
    rdy = 1'b1;
    n = 0;
    while (done !== 1'b1) tick(n);
    repeat (2) @(posedge clk);
    #1;
    chk("idle", 48'(idle), 48'h0);
    chk("pc", 48'(pc), 48'(boot_sel_pkg::WAKE_VECTOR));
    chk("sel pin", 48'(sel_wire), 48'(s));
    chk("sel drive", 48'(sel_o), 48'h1);
    chk("sel oe", 48'(sel_oe), 48'h0);
  endtask : run_mode
  initial begin
    clk = 1'b0; nrst = 1'b0; eb = 1'b0; lb = 1'b0; owner = 1'b1;
    wide = 1'b0; rdy = 1'b1; go = 1'b0; hold_low = 1'b0; ubits = 5'h08;
    err_count = 0;
    check_count = 0;
    void'($urandom(19));
    repeat (3) @(posedge clk);
    run_mode(1, 0, 1, 0, boot_sel_pkg::MODE_EPROM, 6, 8,
             boot_sel_pkg::DMA_CH_EXT);
    run_mode(1, 1, 0, 1, boot_sel_pkg::MODE_EPROM, 6, 8,
             boot_sel_pkg::DMA_CH_EXT);
    run_mode(0, 0, 1, 0, boot_sel_pkg::MODE_HOST, 6, 8,
             boot_sel_pkg::DMA_CH_EXT);
    run_mode(0, 0, 1, 1, boot_sel_pkg::MODE_HOST, 3, 16,
             boot_sel_pkg::DMA_CH_EXT);
    run_mode(0, 1, 1, 0, boot_sel_pkg::MODE_LINK, 12, 4,
             boot_sel_pkg::DMA_CH_LINK);
    run_mode(0, 1, 0, 0, boot_sel_pkg::MODE_SPI, 3, 16,
             boot_sel_pkg::DMA_CH_SPI);
    run_mode(0, 0, 0, 0, boot_sel_pkg::MODE_NONE, 6, 8, 4'h0);
    wrap_up();
  end
endmodule : tb_boot_mode_select_loader
`default_nettype wire
